/* verilog/svlt_pkg.sv */
// Constants and types for the servo loop tuning core
// How it works
// - Torque filter 0..250, default 4, all modes
// - Larger filter constant gives slower torque response
// - Tuning engine loads speed and position gains
// - Speed gain 1..2000 Hz, integral 2..10000
// - More gain or less integral, faster response
// - Integral unit selectable as 0.01 ms
// - Position gain 1..200 per second, default 40
// - Error beyond overflow level raises position alarm
// - Feed-forward 0..100 percent, position mode only
// - Switch bits A,B zero select speed mode
// - Proportional input open PI, closed P in speed mode only
// - Speed mode uses speed input, ignores torque
`default_nettype none
package svlt_pkg;
	localparam int AW = 8;
	localparam int DW = 16;
	localparam logic [7:0] OFS_MSW = 8'h00;
	localparam logic [7:0] OFS_TF = 8'h01;
	localparam logic [7:0] OFS_KV = 8'h02;
	localparam logic [7:0] OFS_TI = 8'h03;
	localparam logic [7:0] OFS_KP = 8'h04;
	localparam logic [7:0] OFS_OVL = 8'h05;
	localparam logic [7:0] OFS_FF = 8'h06;
	localparam logic [7:0] OFS_STAT = 8'h07;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_ERR = 8'h09;
	// Memory switch field positions
	localparam int MSW_A = 0;
	localparam int MSW_B = 1;
	localparam int MSW_UNIT = 2;
	localparam logic [15:0] MSW_MASK = 16'h0007;
	localparam logic [15:0] TF_MIN = 16'h0000;
	localparam logic [15:0] TF_MAX = 16'h00fa;
	localparam logic [15:0] TF_RST = 16'h0004;
	localparam logic [15:0] KV_MIN = 16'h0001;
	localparam logic [15:0] KV_MAX = 16'h07d0;
	localparam logic [15:0] KV_RST = 16'h0028;
	localparam logic [15:0] TI_MIN = 16'h0002;
	localparam logic [15:0] TI_MAX = 16'h2710;
	localparam logic [15:0] TI_RST = 16'h0014;
	localparam logic [15:0] KP_MIN = 16'h0001;
	localparam logic [15:0] KP_MAX = 16'h00c8;
	localparam logic [15:0] KP_RST = 16'h0028;
	localparam logic [15:0] OVL_RST = 16'h0400;
	localparam logic [15:0] FF_MIN = 16'h0000;
	localparam logic [15:0] FF_MAX = 16'h0064;
	localparam logic [15:0] FF_RST = 16'h0000;
	// Status bits
	localparam int ST_OVF = 0;
	localparam int ST_CHG = 1;
	localparam int NSTAT = 2;
	// Timing
	localparam int CLK_NS = 50;
	localparam int SAMPLE_NS = 50000;
	localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int TEN_US_NS = 10000;
	localparam int TEN_US_CYC = TEN_US_NS / CLK_NS;
	// Fixed-point scaling
	localparam int SPD_SHIFT = 6;
	localparam int KP_SHIFT = 4;
	localparam int KV_SHIFT = 6;
	localparam int FF_MUL = 41;
	localparam int FF_SHIFT = 6;
	typedef enum logic [1:0] {
		MODE_SPEED = 2'b00,
		MODE_POSITION = 2'b01,
		MODE_TORQUE = 2'b10
	} svlt_mode_t;
	typedef enum logic [1:0] {
		ST_WAIT = 2'b00,
		ST_REF = 2'b01,
		ST_SPD = 2'b10,
		ST_OUT = 2'b11
	} svlt_state_t;
endpackage
`default_nettype wire

/* verilog/svlt_tfilt.sv */
// First-order torque reference filter
`timescale 1ns/10ps
`default_nettype none
module svlt_tfilt (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_stb,
	input wire logic signed [15:0] i_x,
	input wire logic [15:0] i_tc,
	output logic signed [15:0] o_y
);
	logic signed [31:0] acc_q;
	logic signed [31:0] acc_d;

	// Shift grows with the constant; zero passes straight through
	function automatic logic [3:0] shift_of(input logic [15:0] tc);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 0; i < 8; i++) begin
			if (tc[i]) begin
				s = 4'(i + 1);
			end
		end
		return s;
	endfunction

	always_comb begin
		acc_d = acc_q;
		if (i_stb) begin
			acc_d = acc_q + (($signed({{8{i_x[15]}}, i_x, 8'h00}) - acc_q) >>> shift_of(i_tc));
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			acc_q <= 32'sh0;
		end else if (i_ce) begin
			acc_q <= acc_d;
		end
	end

	assign o_y = acc_q[23:8];
endmodule
`default_nettype wire

/* verilog/svlt_errcnt.sv */
// Position error pulse counter with overflow detect
`timescale 1ns/10ps
`default_nettype none
module svlt_errcnt (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_en,
	input wire logic i_ref_up,
	input wire logic i_ref_dn,
	input wire logic i_fb_up,
	input wire logic i_fb_dn,
	input wire logic [15:0] i_level,
	output logic signed [23:0] o_err,
	output logic o_ovf
);
	logic signed [23:0] cnt_q;
	logic signed [23:0] cnt_d;
	logic ovf_q;
	logic ovf_d;
	logic signed [23:0] delta;
	logic [23:0] mag;

	always_comb begin
		delta = 24'(signed'({1'b0, i_ref_up})) - 24'(signed'({1'b0, i_ref_dn}))
			- 24'(signed'({1'b0, i_fb_up})) + 24'(signed'({1'b0, i_fb_dn}));
		cnt_d = i_en ? cnt_q + delta : 24'sh0;
		mag = cnt_d[23] ? 24'(-cnt_d) : 24'(cnt_d);
		ovf_d = i_en && (mag > {8'h00, i_level});
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_q <= 24'sh0;
			ovf_q <= 1'b0;
		end else if (i_ce) begin
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
		end
	end

	assign o_err = cnt_q;
	assign o_ovf = ovf_q;
endmodule
`default_nettype wire

/* verilog/svlt_core.sv */
// Servo loop core: tuning registers, speed and position loops
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module svlt_core #(
	parameter int P_MS_CYCLES = svlt_pkg::MS_CYC
) (
	input wire logic I_CLOCK,
	input wire logic I_SRST,
	input wire logic I_CE,
	input wire logic [7:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [15:0] O_RDATA,
	input wire logic I_TUNE_LOAD,
	input wire logic [15:0] I_TUNE_KV,
	input wire logic [15:0] I_TUNE_TI,
	input wire logic [15:0] I_TUNE_KP,
	input wire logic signed [15:0] I_SPEED_REF,
	input wire logic signed [15:0] I_TORQUE_REF,
	input wire logic I_REF_UP,
	input wire logic I_REF_DN,
	input wire logic I_FB_UP,
	input wire logic I_FB_DN,
	input wire logic I_PROPORTIONAL_SELECT_INPUT,
	output logic signed [15:0] O_TORQUE_CMD,
	output logic O_P_CONTROL,
	output logic O_POS_ALARM,
	output logic O_INT
);
	logic [15:0] msw_q, msw_d, tf_q, tf_d, kv_q, kv_d, ti_q, ti_d;
	logic [15:0] kp_q, kp_d, ovl_q, ovl_d, ff_q, ff_d, rdata_q, rdata_d;
	logic [1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic [4:0] s1_q, s2_q, s3_q;
	logic [4:0] rise;
	svlt_pkg::svlt_state_t st_q, st_d;
	svlt_pkg::svlt_mode_t mode;
	logic [15:0] smp_q, smp_d, unit_q, unit_d, tic_q, tic_d, unit_lim;
	logic due_q, due_d, pi_act, pcon, flt_stb_q, flt_stb_d;
	logic signed [11:0] fbc_q, fbc_d, refc_q, refc_d;
	logic signed [11:0] fbr_q, fbr_d, refr_q, refr_d;
	logic signed [15:0] cmd_q, cmd_d, serr_q, serr_d, raw_q, raw_d, integ_q, integ_d;
	logic signed [31:0] pterm_q, pterm_d;
	logic signed [23:0] perr;
	logic ovf;

	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sd32767) begin
			return 16'sh7fff;
		end else if (v < -32'sd32768) begin
			return 16'sh8000;
		end
		return v[15:0];
	endfunction

	function automatic logic signed [11:0] step(input logic signed [11:0] c,
		input logic up, input logic dn);
		return c + 12'(signed'({1'b0, up})) - 12'(signed'({1'b0, dn}));
	endfunction

	// Pins are asynchronous to the core clock
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
			s3_q <= 5'h00;
		end else if (I_CE) begin
			s1_q <= {I_PROPORTIONAL_SELECT_INPUT, I_FB_DN, I_FB_UP, I_REF_DN, I_REF_UP};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign rise = s2_q & ~s3_q;
	assign pcon = s2_q[4];

	// bits A,B zero give speed mode
	always_comb begin
		case ({msw_q[svlt_pkg::MSW_B], msw_q[svlt_pkg::MSW_A]})
			2'b00: begin
				mode = svlt_pkg::MODE_SPEED;
			end
			2'b01: begin
				mode = svlt_pkg::MODE_POSITION;
			end
			default: begin
				mode = svlt_pkg::MODE_TORQUE;
			end
		endcase
	end

	// closed input selects P in speed mode
	assign O_P_CONTROL = (mode == svlt_pkg::MODE_SPEED) && pcon;
	assign pi_act = (mode != svlt_pkg::MODE_TORQUE) && !O_P_CONTROL;

	svlt_errcnt u_errcnt (
		.i_clk(I_CLOCK),
		.i_srst(I_SRST),
		.i_ce(I_CE),
		.i_en(mode == svlt_pkg::MODE_POSITION),
		.i_ref_up(rise[0]),
		.i_ref_dn(rise[1]),
		.i_fb_up(rise[2]),
		.i_fb_dn(rise[3]),
		.i_level(ovl_q),
		.o_err(perr),
		.o_ovf(ovf)
	);
	assign O_POS_ALARM = ovf;

	svlt_tfilt u_tfilt (
		.i_clk(I_CLOCK),
		.i_srst(I_SRST),
		.i_ce(I_CE),
		.i_stb(flt_stb_q),
		.i_x(raw_q),
		.i_tc(tf_q),
		.o_y(O_TORQUE_CMD)
	);

	// integral time base, ms or 0.01 ms
	assign unit_lim = msw_q[svlt_pkg::MSW_UNIT] ? 16'(svlt_pkg::TEN_US_CYC) : 16'(P_MS_CYCLES);

	always_comb begin
		unit_d = unit_q + 16'h0001;
		tic_d = tic_q;
		due_d = due_q;
		if (unit_q >= unit_lim - 16'h0001) begin
			unit_d = 16'h0000;
			tic_d = tic_q + 16'h0001;
			if (tic_q >= ti_q - 16'h0001) begin
				tic_d = 16'h0000;
				due_d = 1'b1;
			end
		end
		if (st_q == svlt_pkg::ST_OUT) begin
			due_d = 1'b0;
		end
	end

	// Sample sequencer and loop arithmetic
	always_comb begin
		st_d = st_q;
		smp_d = smp_q + 16'h0001;
		fbc_d = step(fbc_q, rise[2], rise[3]);
		refc_d = step(refc_q, rise[0], rise[1]);
		fbr_d = fbr_q;
		refr_d = refr_q;
		cmd_d = cmd_q;
		serr_d = serr_q;
		pterm_d = pterm_q;
		raw_d = raw_q;
		integ_d = pi_act ? integ_q : 16'sh0;
		flt_stb_d = 1'b0;
		case (st_q)
			svlt_pkg::ST_WAIT: begin
				if (smp_q >= 16'(svlt_pkg::SAMPLE_CYC - 1)) begin
					smp_d = 16'h0000;
					fbr_d = fbc_d;
					refr_d = refc_d;
					fbc_d = 12'sh0;
					refc_d = 12'sh0;
					st_d = svlt_pkg::ST_REF;
				end
			end
			svlt_pkg::ST_REF: begin
				if (mode == svlt_pkg::MODE_POSITION) begin
					// feed-forward from reference rate
					// Gains widened as positive signed so a negative error stays negative
					cmd_d = sat16(((32'(perr) * 32'(signed'({1'b0, kp_q})))
						>>> svlt_pkg::KP_SHIFT)
						+ ((32'(refr_q) * 32'(signed'({1'b0, ff_q})) * svlt_pkg::FF_MUL)
						>>> svlt_pkg::FF_SHIFT));
				end else begin
					// analog speed input is the reference
					cmd_d = I_SPEED_REF;
				end
				st_d = svlt_pkg::ST_SPD;
			end
			svlt_pkg::ST_SPD: begin
				serr_d = sat16(32'(cmd_q) - (32'(fbr_q) <<< svlt_pkg::SPD_SHIFT));
				pterm_d = 32'(sat16((32'(serr_d) * 32'(signed'({1'b0, kv_q})))
					>>> svlt_pkg::KV_SHIFT));
				st_d = svlt_pkg::ST_OUT;
			end
			default: begin
				if (pi_act && due_q) begin
					integ_d = sat16(32'(integ_q) + pterm_q);
				end
				// torque input only used in torque mode
				raw_d = (mode == svlt_pkg::MODE_TORQUE) ? I_TORQUE_REF
					: sat16(pterm_q + 32'(integ_d));
				flt_stb_d = 1'b1;
				st_d = svlt_pkg::ST_WAIT;
			end
		endcase
	end

	// Register writes and status
	always_comb begin
		msw_d = msw_q;
		tf_d = tf_q;
		kv_d = kv_q;
		ti_d = ti_q;
		kp_d = kp_q;
		ovl_d = ovl_q;
		ff_d = ff_q;
		mask_d = mask_q;
		rdata_d = 16'h0000;
		ev = 2'b00;
		ev[svlt_pkg::ST_OVF] = ovf;
		ev[svlt_pkg::ST_CHG] = (mode == svlt_pkg::MODE_SPEED) && (s2_q[4] ^ s3_q[4]);
		stat_d = stat_q;
		if (I_WR) begin
			case (I_ADDR)
				svlt_pkg::OFS_MSW: msw_d = I_WDATA & svlt_pkg::MSW_MASK;
				svlt_pkg::OFS_TF: tf_d = clamp(I_WDATA, svlt_pkg::TF_MIN, svlt_pkg::TF_MAX);
				svlt_pkg::OFS_KV: kv_d = clamp(I_WDATA, svlt_pkg::KV_MIN, svlt_pkg::KV_MAX);
				svlt_pkg::OFS_TI: ti_d = clamp(I_WDATA, svlt_pkg::TI_MIN, svlt_pkg::TI_MAX);
				svlt_pkg::OFS_KP: kp_d = clamp(I_WDATA, svlt_pkg::KP_MIN, svlt_pkg::KP_MAX);
				svlt_pkg::OFS_OVL: ovl_d = I_WDATA;
				svlt_pkg::OFS_FF: ff_d = clamp(I_WDATA, svlt_pkg::FF_MIN, svlt_pkg::FF_MAX);
				svlt_pkg::OFS_MASK: mask_d = I_WDATA[1:0];
				default: begin
				end
			endcase
		end
		// tuning result overrides a bus write
		if (I_TUNE_LOAD) begin
			kv_d = clamp(I_TUNE_KV, svlt_pkg::KV_MIN, svlt_pkg::KV_MAX);
			ti_d = clamp(I_TUNE_TI, svlt_pkg::TI_MIN, svlt_pkg::TI_MAX);
			kp_d = clamp(I_TUNE_KP, svlt_pkg::KP_MIN, svlt_pkg::KP_MAX);
		end
		if (I_RD) begin
			case (I_ADDR)
				svlt_pkg::OFS_MSW: rdata_d = msw_q;
				svlt_pkg::OFS_TF: rdata_d = tf_q;
				svlt_pkg::OFS_KV: rdata_d = kv_q;
				svlt_pkg::OFS_TI: rdata_d = ti_q;
				svlt_pkg::OFS_KP: rdata_d = kp_q;
				svlt_pkg::OFS_OVL: rdata_d = ovl_q;
				svlt_pkg::OFS_FF: rdata_d = ff_q;
				svlt_pkg::OFS_STAT: begin
					rdata_d = {14'h0000, stat_q};
					stat_d = 2'b00;
				end
				svlt_pkg::OFS_MASK: rdata_d = {14'h0000, mask_q};
				svlt_pkg::OFS_ERR: rdata_d = perr[15:0];
				default: rdata_d = 16'h0000;
			endcase
		end
		// New events win over a clearing read
		stat_d = stat_d | ev;
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			msw_q <= 16'h0000;
			tf_q <= svlt_pkg::TF_RST;
			kv_q <= svlt_pkg::KV_RST;
			ti_q <= svlt_pkg::TI_RST;
			kp_q <= svlt_pkg::KP_RST;
			ovl_q <= svlt_pkg::OVL_RST;
			ff_q <= svlt_pkg::FF_RST;
			mask_q <= 2'b00;
			stat_q <= 2'b00;
			rdata_q <= 16'h0000;
			st_q <= svlt_pkg::ST_WAIT;
			smp_q <= 16'h0000;
			unit_q <= 16'h0000;
			tic_q <= 16'h0000;
			due_q <= 1'b0;
			fbc_q <= 12'sh0;
			refc_q <= 12'sh0;
			fbr_q <= 12'sh0;
			refr_q <= 12'sh0;
			cmd_q <= 16'sh0;
			serr_q <= 16'sh0;
			pterm_q <= 32'sh0;
			raw_q <= 16'sh0;
			integ_q <= 16'sh0;
			flt_stb_q <= 1'b0;
		end else if (I_CE) begin
			msw_q <= msw_d;
			tf_q <= tf_d;
			kv_q <= kv_d;
			ti_q <= ti_d;
			kp_q <= kp_d;
			ovl_q <= ovl_d;
			ff_q <= ff_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			rdata_q <= rdata_d;
			st_q <= st_d;
			smp_q <= smp_d;
			unit_q <= unit_d;
			tic_q <= tic_d;
			due_q <= due_d;
			fbc_q <= fbc_d;
			refc_q <= refc_d;
			fbr_q <= fbr_d;
			refr_q <= refr_d;
			cmd_q <= cmd_d;
			serr_q <= serr_d;
			pterm_q <= pterm_d;
			raw_q <= raw_d;
			integ_q <= integ_d;
			flt_stb_q <= flt_stb_d;
		end
	end

	assign O_RDATA = rdata_q;
	assign O_INT = |(stat_q & mask_q);

	a_tf_clamp: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
		(I_CE && I_WR && I_ADDR == svlt_pkg::OFS_TF && I_WDATA > 16'h00fa)
		|=> tf_q == 16'h00fa) else $error("torque filter not clamped");
	a_kv_range: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
		kv_q >= 16'h0001 && kv_q <= 16'h07d0) else $error("speed gain out of range");
	a_ti_range: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
		ti_q >= 16'h0002 && ti_q <= 16'h2710) else $error("integral time out of range");
	a_kp_tune: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
		(I_CE && I_TUNE_LOAD && I_TUNE_KP >= 16'h0001 && I_TUNE_KP <= 16'h00c8)
		|=> kp_q == $past(I_TUNE_KP)) else $error("tuned position gain not loaded");
	a_ff_range: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
		ff_q <= 16'h0064) else $error("feed-forward gain above 100");
	a_ovf_status: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
		(I_CE && ovf) |=> stat_q[0]) else $error("overflow alarm not latched");
	a_p_clears: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
		(I_CE && st_q == svlt_pkg::ST_OUT && O_P_CONTROL) |=> integ_q == 16'sh0)
		else $error("integrator kept in P control");
	a_read_clear: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
		(I_CE && I_RD && I_ADDR == svlt_pkg::OFS_STAT && ev == 2'b00) |=> stat_q == 2'b00)
		else $error("status not cleared by read");
	a_rdata_once: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
		(I_CE && !I_RD) |=> O_RDATA == 16'h0000) else $error("read data outside slot");
endmodule
`default_nettype wire

/* bench/svlt_host_model.sv */
// Host controller and motor pulse model
`timescale 1ns/10ps
`default_nettype none
module svlt_host_model (
	input wire logic i_clk,
	output logic o_ref_up,
	output logic o_ref_dn,
	output logic o_fb_up,
	output logic o_fb_dn,
	output logic o_select
);
	initial begin
		o_ref_up = 1'b0;
		o_ref_dn = 1'b0;
		o_fb_up = 1'b0;
		o_fb_dn = 1'b0;
		o_select = 1'b0;
	end
	// Two high, two low: slower than the merge limit
	task automatic pulses(input int kind, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			case (kind)
				0: o_ref_up <= 1'b1;
				1: o_fb_up <= 1'b1;
				2: o_ref_dn <= 1'b1;
				default: o_fb_dn <= 1'b1;
			endcase
			repeat (2) @(posedge i_clk);
			o_ref_up <= 1'b0;
			o_fb_up <= 1'b0;
			o_ref_dn <= 1'b0;
			o_fb_dn <= 1'b0;
			@(posedge i_clk);
		end
		repeat (6) @(posedge i_clk);
	endtask
	task automatic select(input logic closed);
		@(posedge i_clk);
		o_select <= closed;
		repeat (6) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

/* bench/servo_loop_tuning_parameters_bench.sv */
// Self-checking bench for the servo loop core
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("BAD %0t got %h want %h", $time, (g), (e)); end end
module servo_loop_tuning_parameters_bench;
	logic clk = 1'b0, srst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, tl = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wd = 16'h0000, rdata, d, tkv = 16'h0000, tti = 16'h0000, tkp = 16'h0000;
	logic signed [15:0] sref = 16'sh0000, tref = 16'sh0000, tq;
	logic ru, rdn, fu, fdn, sel, pctl, alarm, irq;
	int fails = 0, checks = 0;
	logic [31:0] seed = 32'hdd99;
	logic [15:0] lo [5], hi [5], rv [10];
	logic [7:0] ad [5];
	always #25 clk = ~clk;
	svlt_host_model host (.i_clk(clk), .o_ref_up(ru), .o_ref_dn(rdn), .o_fb_up(fu),
		.o_fb_dn(fdn), .o_select(sel));
	svlt_core #(.P_MS_CYCLES(20)) DUT (.I_CLOCK(clk), .I_SRST(srst), .I_CE(ce),
		.I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
		.I_TUNE_LOAD(tl), .I_TUNE_KV(tkv), .I_TUNE_TI(tti), .I_TUNE_KP(tkp),
		.I_SPEED_REF(sref), .I_TORQUE_REF(tref), .I_REF_UP(ru), .I_REF_DN(rdn),
		.I_FB_UP(fu), .I_FB_DN(fdn), .I_PROPORTIONAL_SELECT_INPUT(sel),
		.O_TORQUE_CMD(tq), .O_P_CONTROL(pctl), .O_POS_ALARM(alarm), .O_INT(irq));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [15:0] clampv(input logic [15:0] v, lo, hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
	task automatic wreg(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic tune(input logic [15:0] kv, input logic [15:0] ti, input logic [15:0] kp);
		@(posedge clk);
		tl <= 1'b1;
		tkv <= kv;
		tti <= ti;
		tkp <= kp;
		@(posedge clk);
		tl <= 1'b0;
	endtask
	task automatic samples(input int n);
		repeat (n * svlt_pkg::SAMPLE_CYC) @(posedge clk);
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#3000000;
		fails++;
		tally_and_finish();
	end
	initial begin
		ad = '{svlt_pkg::OFS_TF, svlt_pkg::OFS_KV, svlt_pkg::OFS_TI, svlt_pkg::OFS_KP,
			svlt_pkg::OFS_FF};
		lo = '{svlt_pkg::TF_MIN, svlt_pkg::KV_MIN, svlt_pkg::TI_MIN, svlt_pkg::KP_MIN,
			svlt_pkg::FF_MIN};
		hi = '{svlt_pkg::TF_MAX, svlt_pkg::KV_MAX, svlt_pkg::TI_MAX, svlt_pkg::KP_MAX,
			svlt_pkg::FF_MAX};
		rv = '{16'h0000, svlt_pkg::TF_RST, svlt_pkg::KV_RST, svlt_pkg::TI_RST,
			svlt_pkg::KP_RST, svlt_pkg::OVL_RST, svlt_pkg::FF_RST,
			16'h0000, 16'h0000, 16'h0000};
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (int a = 0; a < 10; a++) begin
			rreg(a[7:0], d);
			`CHK(d, rv[a])
		end
		rreg(8'h0a, d);
		`CHK(d, 16'h0000)
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			int k;
			logic [15:0] w;
			seed = xs(seed);
			k = seed[2:0] % 5;
			w = (i < 5) ? 16'h0000 : ((i < 10) ? 16'hffff : seed[31:16]);
			if (i < 10) k = i % 5;
			wreg(ad[k], w);
			rreg(ad[k], d);
			`CHK(d, clampv(w, lo[k], hi[k]))
		end
		$display("test clamp done");
		seed = xs(seed);
		tune(seed[15:0], seed[31:16], 16'h00c9);
		rreg(svlt_pkg::OFS_KV, d);
		`CHK(d, clampv(tkv, svlt_pkg::KV_MIN, svlt_pkg::KV_MAX))
		rreg(svlt_pkg::OFS_TI, d);
		`CHK(d, clampv(tti, svlt_pkg::TI_MIN, svlt_pkg::TI_MAX))
		rreg(svlt_pkg::OFS_KP, d);
		`CHK(d, svlt_pkg::KP_MAX)
		tune(16'h0000, 16'h0001, 16'h0001);
		rreg(svlt_pkg::OFS_KV, d);
		`CHK(d, svlt_pkg::KV_MIN)
		rreg(svlt_pkg::OFS_TI, d);
		`CHK(d, svlt_pkg::TI_MIN)
		rreg(svlt_pkg::OFS_KP, d);
		`CHK(d, 16'h0001)
		// Clock enable low: the second write must not land
		wreg(svlt_pkg::OFS_TF, 16'h0005);
		ce <= 1'b0;
		wreg(svlt_pkg::OFS_TF, 16'h0007);
		ce <= 1'b1;
		rreg(svlt_pkg::OFS_TF, d);
		`CHK(d, 16'h0005)
		$display("test tune done");
		// Position mode, level 5, overflow unmasked
		wreg(svlt_pkg::OFS_MSW, 16'h0001);
		wreg(svlt_pkg::OFS_FF, 16'h0050);
		wreg(svlt_pkg::OFS_OVL, 16'h0005);
		wreg(svlt_pkg::OFS_MASK, 16'h0001);
		rreg(svlt_pkg::OFS_STAT, d);
		host.pulses(0, 5);
		`CHK(alarm, 1'b0)
		host.pulses(0, 1);
		`CHK(alarm, 1'b1)
		`CHK(irq, 1'b1)
		rreg(svlt_pkg::OFS_ERR, d);
		`CHK(d, 16'h0006)
		rreg(svlt_pkg::OFS_STAT, d);
		`CHK(d[0], 1'b1)
		wreg(svlt_pkg::OFS_MASK, 16'h0000);
		#1;
		`CHK(irq, 1'b0)
		host.pulses(1, 6);
		`CHK(alarm, 1'b0)
		host.pulses(2, 6);
		`CHK(alarm, 1'b1)
		rreg(svlt_pkg::OFS_ERR, d);
		`CHK(d, 16'hfffa)
		host.pulses(3, 6);
		`CHK(alarm, 1'b0)
		rreg(svlt_pkg::OFS_STAT, d);
		rreg(svlt_pkg::OFS_STAT, d);
		`CHK(d, 16'h0000)
		host.select(1'b1);
		`CHK(pctl, 1'b0)
		host.select(1'b0);
		$display("test position done");
		wreg(svlt_pkg::OFS_MSW, 16'h0002);
		wreg(svlt_pkg::OFS_TF, 16'h0000);
		tref <= 16'sd1000;
		samples(3);
		`CHK(tq, 16'sd1000)
		tref <= 16'sd0;
		wreg(svlt_pkg::OFS_TF, 16'h00fa);
		samples(3);
		tref <= 16'sd1000;
		samples(2);
		`CHK(tq < 16'sd1000, 1'b1)
		$display("test filter done");
		wreg(svlt_pkg::OFS_MSW, 16'hfffc);
		rreg(svlt_pkg::OFS_MSW, d);
		`CHK(d, svlt_pkg::MSW_MASK & 16'hfffc)
		wreg(svlt_pkg::OFS_TF, 16'h0000);
		wreg(svlt_pkg::OFS_MASK, 16'h0002);
		samples(3);
		`CHK(tq, 16'sd0)
		host.select(1'b1);
		`CHK(pctl, 1'b1)
		samples(1);
		`CHK(irq, 1'b1)
		rreg(svlt_pkg::OFS_STAT, d);
		`CHK(d[1], 1'b1)
		host.select(1'b0);
		`CHK(pctl, 1'b0)
		$display("test speed done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
